// ==== rtl/gpb_pkg.sv ====
package gpb_pkg;
  localparam int unsigned GPB_AW = 12;
  localparam logic [7:0] GPB_IDX_PA_DATA = 8'h05;
  localparam logic [7:0] GPB_IDX_PB_DATA = 8'h06;
  localparam logic [7:0] GPB_IDX_OPTION = 8'h81;
  localparam logic [7:0] GPB_IDX_PA_DIR = 8'h85;
  localparam logic [7:0] GPB_IDX_PB_DIR = 8'h86;
  localparam logic [7:0] GPB_IDX_CMP = 8'h9C;
  localparam logic [7:0] GPB_IDX_VREF = 8'h9D;
  localparam logic [7:0] GPB_IDX_ANA = 8'h9F;
  localparam logic [7:0] GPB_IDX_IRQ_STAT = 8'h0B;
  localparam logic [7:0] GPB_IDX_IRQ_CLR = 8'h0C;
  localparam logic [7:0] GPB_IDX_IRQ_EN = 8'h0D;
  localparam logic [7:0] GPB_IDX_LVP = 8'h0E;
  localparam logic [7:0] GPB_RST_OPTION = 8'hFF;
  localparam logic [5:0] GPB_RST_PA_DIR = 6'h3F;
  localparam logic [7:0] GPB_RST_PB_DIR = 8'hFF;
  localparam logic [7:0] GPB_RST_CMP = 8'h07;
  localparam logic [7:0] GPB_RST_VREF = 8'h00;
  localparam logic [7:0] GPB_RST_ANA = 8'h00;
  localparam logic GPB_RST_LVP = 1'b1;
  localparam logic [1:0] GPB_RST_IRQ_EN = 2'h0;
  localparam logic [7:0] GPB_MASK_CMP = 8'h3F;
  localparam logic [7:0] GPB_MASK_VREF = 8'hEF;
  localparam logic [7:0] GPB_MASK_ANA = 8'hCF;
  localparam int unsigned GPB_OPT_PULLUP_DIS = 7;
  localparam int unsigned GPB_OPT_EDGE = 6;
  localparam int unsigned GPB_IRQ_CHG = 0;
  localparam int unsigned GPB_IRQ_EXT = 1;
  localparam int unsigned GPB_PA_OD = 4;
  localparam int unsigned GPB_PB_PROG = 3;
  localparam int unsigned GPB_PB_EXT = 0;
  localparam int unsigned GPB_CHG_LO = 4;
  localparam logic [3:0] GPB_ANA_DIG0 = 4'h6;
  localparam logic [3:0] GPB_ANA_DIG1 = 4'h7;
  localparam logic [5:0] GPB_PA_ANA_PINS = 6'h2F;
  typedef struct packed {
    logic ext;
    logic chg;
  } gpb_irq_s;
  typedef enum logic [1:0] {
    GPB_ST_IDLE = 2'b01,
    GPB_ST_RESP = 2'b10
  } gpb_apb_e;
endpackage : gpb_pkg

// ==== rtl/gpb_ports.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpb_ports
  import gpb_pkg::*;
#(
  parameter int unsigned PA_W = 6,
  parameter int unsigned PB_W = 8
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [GPB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [5:0] pa_in_i,
  output logic [5:0] pa_out_o,
  output logic [5:0] pa_oe_o,
  input wire logic [7:0] pb_in_i,
  output logic [7:0] pb_out_o,
  output logic [7:0] pb_oe_o,
  output logic [7:0] pb_pullup_o,
  output logic timer_clk_o,
  input wire logic sleep_i,
  output logic wake_o,
  output logic irq_o
);
  if (PA_W != 6 || PB_W != 8) begin : g_chk
    $error("gpb_ports: port widths are fixed at 6 and 8");
  end

  function automatic logic hit(input logic [GPB_AW-1:0] a, input logic [7:0] idx);
    return a == {2'b00, idx, 2'b00};
  endfunction : hit

  gpb_apb_e state_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [5:0] pa_meta_reg;
  logic [5:0] pa_sync_reg;
  logic [7:0] pb_meta_reg;
  logic [7:0] pb_sync_reg;
  logic [5:0] pa_lat_reg;
  logic [7:0] pb_lat_reg;
  logic [5:0] pa_dir_reg;
  logic [7:0] pb_dir_reg;
  logic [7:0] opt_reg;
  logic [7:0] cmp_reg;
  logic [7:0] vref_reg;
  logic [7:0] ana_reg;
  logic lvp_reg;
  logic [3:0] old_reg;
  logic ext_prev_reg;
  gpb_irq_s stat_reg;
  gpb_irq_s stat_next;
  gpb_irq_s en_reg;
  logic [5:0] pa_out_reg;
  logic [5:0] pa_oe_reg;
  logic [7:0] pb_out_reg;
  logic [7:0] pb_oe_reg;
  logic [7:0] pb_pu_reg;
  logic tclk_reg;
  logic wake_reg;
  logic irq_reg;

  logic acc_start;
  logic wr_go;
  logic rd_go;
  logic mapped;
  logic pb_touch;
  logic [5:0] pa_ana;
  logic [5:0] pa_rd;
  logic [7:0] pb_rd;
  logic mismatch;
  logic ext_edge;
  logic [31:0] rd_val;
  logic [7:0] wb;

  assign wb = pwdata_i[7:0];
  assign acc_start = ce_i && psel_i && penable_i && state_reg == GPB_ST_IDLE;
  assign wr_go = ce_i && psel_i && penable_i && pwrite_i && state_reg == GPB_ST_RESP && !pslverr_reg;
  assign rd_go = ce_i && psel_i && penable_i && !pwrite_i && state_reg == GPB_ST_RESP;
  assign pb_touch = (wr_go || rd_go) && hit(paddr_i, GPB_IDX_PB_DATA);

  always_comb begin
    mapped = 1'b1;
    if (hit(paddr_i, GPB_IDX_PA_DATA)) begin
      mapped = 1'b1;
    end else if (hit(paddr_i, GPB_IDX_PB_DATA)) begin
      mapped = 1'b1;
    end else if (hit(paddr_i, GPB_IDX_OPTION) || hit(paddr_i, GPB_IDX_PA_DIR)) begin
      mapped = 1'b1;
    end else if (hit(paddr_i, GPB_IDX_PB_DIR) || hit(paddr_i, GPB_IDX_CMP)) begin
      mapped = 1'b1;
    end else if (hit(paddr_i, GPB_IDX_VREF) || hit(paddr_i, GPB_IDX_ANA)) begin
      mapped = 1'b1;
    end else if (hit(paddr_i, GPB_IDX_IRQ_STAT) || hit(paddr_i, GPB_IDX_IRQ_CLR)) begin
      mapped = 1'b1;
    end else if (hit(paddr_i, GPB_IDX_IRQ_EN) || hit(paddr_i, GPB_IDX_LVP)) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // analog pins read zero; only codes 011x release all of them
  assign pa_ana = (ana_reg[3:0] == GPB_ANA_DIG0 || ana_reg[3:0] == GPB_ANA_DIG1) ? 6'h00 : GPB_PA_ANA_PINS;
  assign pa_rd = pa_sync_reg & ~pa_ana;
  always_comb begin
    pb_rd = pb_sync_reg;
    if (lvp_reg) begin
      pb_rd[GPB_PB_PROG] = 1'b0;
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit(paddr_i, GPB_IDX_PA_DATA)) begin
      rd_val[5:0] = pa_rd;
    end else if (hit(paddr_i, GPB_IDX_PB_DATA)) begin
      rd_val[7:0] = pb_rd;
    end else if (hit(paddr_i, GPB_IDX_OPTION)) begin
      rd_val[7:0] = opt_reg;
    end else if (hit(paddr_i, GPB_IDX_PA_DIR)) begin
      rd_val[5:0] = pa_dir_reg;
    end else if (hit(paddr_i, GPB_IDX_PB_DIR)) begin
      rd_val[7:0] = pb_dir_reg;
    end else if (hit(paddr_i, GPB_IDX_CMP)) begin
      rd_val[7:0] = cmp_reg;
    end else if (hit(paddr_i, GPB_IDX_VREF)) begin
      rd_val[7:0] = vref_reg;
    end else if (hit(paddr_i, GPB_IDX_ANA)) begin
      rd_val[7:0] = ana_reg;
    end else if (hit(paddr_i, GPB_IDX_IRQ_STAT)) begin
      rd_val[1:0] = stat_reg;
    end else if (hit(paddr_i, GPB_IDX_IRQ_EN)) begin
      rd_val[1:0] = en_reg;
    end else if (hit(paddr_i, GPB_IDX_LVP)) begin
      rd_val[0] = lvp_reg;
    end else begin
      rd_val = 32'h0000_0000;
    end
  end

  // one wait state buys registered pready and prdata
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= GPB_ST_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      case (state_reg)
        GPB_ST_IDLE: begin
          if (psel_i && penable_i) begin
            state_reg <= GPB_ST_RESP;
            pready_reg <= 1'b1;
            pslverr_reg <= !mapped;
            prdata_reg <= mapped ? rd_val : 32'h0000_0000;
          end
        end
        GPB_ST_RESP: begin
          state_reg <= GPB_ST_IDLE;
          pready_reg <= 1'b0;
          pslverr_reg <= 1'b0;
          prdata_reg <= 32'h0000_0000;
        end
        default: begin
          state_reg <= GPB_ST_IDLE;
          pready_reg <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pa_meta_reg <= 6'h00;
      pa_sync_reg <= 6'h00;
      pb_meta_reg <= 8'h00;
      pb_sync_reg <= 8'h00;
    end else if (ce_i) begin
      pa_meta_reg <= pa_in_i;
      pa_sync_reg <= pa_meta_reg;
      pb_meta_reg <= pb_in_i;
      pb_sync_reg <= pb_meta_reg;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pa_lat_reg <= 6'h00;
      pb_lat_reg <= 8'h00;
      pa_dir_reg <= GPB_RST_PA_DIR;
      pb_dir_reg <= GPB_RST_PB_DIR;
      opt_reg <= GPB_RST_OPTION;
      cmp_reg <= GPB_RST_CMP;
      vref_reg <= GPB_RST_VREF;
      ana_reg <= GPB_RST_ANA;
      lvp_reg <= GPB_RST_LVP;
      en_reg <= GPB_RST_IRQ_EN;
    end else if (wr_go) begin
      if (hit(paddr_i, GPB_IDX_PA_DATA)) begin
        pa_lat_reg <= wb[5:0];
      end else if (hit(paddr_i, GPB_IDX_PB_DATA)) begin
        pb_lat_reg <= wb;
      end else if (hit(paddr_i, GPB_IDX_OPTION)) begin
        opt_reg <= wb;
      end else if (hit(paddr_i, GPB_IDX_PA_DIR)) begin
        pa_dir_reg <= wb[5:0];
      end else if (hit(paddr_i, GPB_IDX_PB_DIR)) begin
        pb_dir_reg <= wb;
      end else if (hit(paddr_i, GPB_IDX_CMP)) begin
        cmp_reg <= wb & GPB_MASK_CMP;
      end else if (hit(paddr_i, GPB_IDX_VREF)) begin
        vref_reg <= wb & GPB_MASK_VREF;
      end else if (hit(paddr_i, GPB_IDX_ANA)) begin
        ana_reg <= wb & GPB_MASK_ANA;
      end else if (hit(paddr_i, GPB_IDX_IRQ_EN)) begin
        en_reg <= wb[1:0];
      end else if (hit(paddr_i, GPB_IDX_LVP)) begin
        lvp_reg <= wb[0];
      end
    end
  end

  // old-value latch refreshed on every port B data access, so a read ends the mismatch that had already set the change flag
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      old_reg <= 4'h0;
      ext_prev_reg <= 1'b0;
    end else if (ce_i) begin
      ext_prev_reg <= pb_sync_reg[GPB_PB_EXT];
      if (pb_touch) begin
        old_reg <= pb_sync_reg[7:GPB_CHG_LO];
      end
    end
  end

  assign mismatch = |((pb_sync_reg[7:GPB_CHG_LO] ^ old_reg) & pb_dir_reg[7:GPB_CHG_LO]);
  assign ext_edge = opt_reg[GPB_OPT_EDGE]
    ? (pb_sync_reg[GPB_PB_EXT] && !ext_prev_reg)
    : (!pb_sync_reg[GPB_PB_EXT] && ext_prev_reg);

  always_comb begin
    stat_next = stat_reg;
    if (wr_go && hit(paddr_i, GPB_IDX_IRQ_CLR)) begin
      stat_next = stat_reg & ~gpb_irq_s'(wb[1:0]);
    end
    // set beats clear in the same cycle
    if (mismatch) begin
      stat_next.chg = 1'b1;
    end
    if (ext_edge) begin
      stat_next.ext = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stat_reg <= '0;
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else if (ce_i) begin
      stat_reg <= stat_next;
      irq_reg <= |(stat_next & en_reg);
      wake_reg <= sleep_i && stat_next.chg && en_reg.chg;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pa_out_reg <= 6'h00;
      pa_oe_reg <= 6'h00;
      pb_out_reg <= 8'h00;
      pb_oe_reg <= 8'h00;
      pb_pu_reg <= 8'h00;
      tclk_reg <= 1'b0;
    end else if (ce_i) begin
      pa_out_reg <= pa_lat_reg;
      pa_out_reg[GPB_PA_OD] <= 1'b0;
      pa_oe_reg <= ~pa_dir_reg;
      pa_oe_reg[GPB_PA_OD] <= !pa_dir_reg[GPB_PA_OD] && !pa_lat_reg[GPB_PA_OD];
      tclk_reg <= pa_sync_reg[GPB_PA_OD];
      pb_out_reg <= pb_lat_reg;
      pb_oe_reg <= ~pb_dir_reg;
      pb_oe_reg[GPB_PB_PROG] <= !pb_dir_reg[GPB_PB_PROG] && !lvp_reg;
      pb_pu_reg <= pb_dir_reg & {8{!opt_reg[GPB_OPT_PULLUP_DIS]}};
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign pa_out_o = pa_out_reg;
  assign pa_oe_o = pa_oe_reg;
  assign pb_out_o = pb_out_reg;
  assign pb_oe_o = pb_oe_reg;
  assign pb_pullup_o = pb_pu_reg;
  assign timer_clk_o = tclk_reg;
  assign wake_o = wake_reg;
  assign irq_o = irq_reg;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_access;
    acc_start;
  endsequence
  sequence s_answer;
    pready_o ##1 !pready_o;
  endsequence

  a_oe_follows_dir: assert property (ce_i |=> pb_oe_o[7:4] == ~$past(pb_dir_reg[7:4]))
    else $error("port b enable does not follow direction");
  a_pullup_rule: assert property (ce_i |=> pb_pullup_o == ($past(pb_dir_reg) & {8{!$past(opt_reg[7])}}))
    else $error("pull-up state wrong");
  a_pullup_reset: assert property ($rose(resetn_i) |-> pb_pullup_o == 8'h00)
    else $error("pull-ups on after reset");
  a_chg_sets: assert property (ce_i && mismatch |=> stat_reg.chg)
    else $error("change flag not set on mismatch");
  a_out_excluded: assert property (ce_i && pb_dir_reg[7:4] == 4'h0 && !stat_reg.chg && !wr_go |=> !stat_reg.chg)
    else $error("output pins raised change flag");
  a_touch_ends: assert property (pb_touch |=> old_reg == $past(pb_sync_reg[7:4]))
    else $error("access did not refresh old value");
  a_ext_edge: assert property (ce_i && ext_edge |=> stat_reg.ext ##0 irq_o == |(stat_reg & en_reg))
    else $error("external edge not flagged");
  a_prog_pin: assert property (ce_i && lvp_reg |=> !pb_oe_o[3])
    else $error("program pin driven while low-voltage mode on");
  a_open_drain: assert property (pa_out_o[4] == 1'b0)
    else $error("open-drain pin driven high");
  a_upper_zero: assert property (pready_o && (hit(paddr_i, GPB_IDX_PA_DATA) || hit(paddr_i, GPB_IDX_PA_DIR))
    |-> prdata_o[31:6] == 26'h0)
    else $error("unimplemented bits read nonzero");
  a_sync_delay: assert property (ce_i [*3] |-> pb_sync_reg == $past(pb_in_i, 2))
    else $error("synchroniser latency wrong");
  a_wake_chg: assert property (ce_i && sleep_i && stat_next.chg && en_reg.chg |=> wake_o)
    else $error("no wake on change");
  a_apb_answer: assert property (s_access |=> s_answer)
    else $error("bus answer timing wrong");
endmodule : gpb_ports
`default_nettype wire

// ==== rtl/gpb_unused_placeholder_none.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== tb/gpb_pins.sv ====
`timescale 1ns/1ps
`default_nettype none
// pins outside the ports: keypad and other circuits
module gpb_pins (
  input wire logic mclk_i,
  input wire logic [5:0] pa_out_i,
  input wire logic [5:0] pa_oe_i,
  input wire logic [7:0] pb_out_i,
  input wire logic [7:0] pb_oe_i,
  input wire logic [7:0] pb_pullup_i,
  input wire logic [5:0] ext_a_i,
  input wire logic [7:0] ext_b_i,
  input wire logic [7:0] ext_b_en_i,
  output logic [5:0] pa_pin_o,
  output logic [7:0] pb_pin_o
);
  logic [7:0] junk_reg = 8'h5A;
  // floating line without pull-up shows a changing pattern, never a held value
  always @(posedge mclk_i) begin
    junk_reg <= ~junk_reg;
  end
  // open drain bit 4 only ever drives low, so the same mux holds
  assign pa_pin_o = (pa_oe_i & pa_out_i) | (~pa_oe_i & ext_a_i);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pb_oe_i[i]) pb_pin_o[i] = pb_out_i[i];
      else if (ext_b_en_i[i]) pb_pin_o[i] = ext_b_i[i];
      else if (pb_pullup_i[i]) pb_pin_o[i] = 1'b1;
      else pb_pin_o[i] = junk_reg[i];
    end
  end
endmodule : gpb_pins
`default_nettype wire

// ==== tb/gpio_ports_a_b_change_irq_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_a_b_change_irq_test;
  import gpb_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep = 1'b0;
  logic [GPB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, d;
  logic pready, pslverr, err, timer_clk, wake, irq;
  logic ce = 1'b1;
  logic [5:0] pa_in, pa_out, pa_oe, ext_a = 6'h3F;
  logic [7:0] pb_in, pb_out, pb_oe, pb_pullup, ext_b = 8'h3C, ext_en = 8'hFF;
  int fail_count = 0;
  int checked = 0;
  logic [7:0] rst_idx [8] = '{GPB_IDX_OPTION, GPB_IDX_PA_DIR, GPB_IDX_PB_DIR, GPB_IDX_CMP,
    GPB_IDX_VREF, GPB_IDX_ANA, GPB_IDX_IRQ_EN, GPB_IDX_LVP};
  logic [7:0] rst_val [8] = '{8'hFF, 8'h3F, 8'hFF, 8'h07, 8'h00, 8'h00, 8'h00, 8'h01};

  initial begin
    forever #20 mclk = ~mclk;
  end

  gpb_ports u_gpb_ports (.mclk_i(mclk), .resetn_i(resetn), .ce_i(ce), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pa_in_i(pa_in),
    .pa_out_o(pa_out), .pa_oe_o(pa_oe), .pb_in_i(pb_in), .pb_out_o(pb_out), .pb_oe_o(pb_oe),
    .pb_pullup_o(pb_pullup), .timer_clk_o(timer_clk), .sleep_i(sleep), .wake_o(wake), .irq_o(irq));

  gpb_pins u_gpb_pins (.mclk_i(mclk), .pa_out_i(pa_out), .pa_oe_i(pa_oe), .pb_out_i(pb_out),
    .pb_oe_i(pb_oe), .pb_pullup_i(pb_pullup), .ext_a_i(ext_a), .ext_b_i(ext_b),
    .ext_b_en_i(ext_en), .pa_pin_o(pa_in), .pb_pin_o(pb_in));

  task automatic test_done;
    if (fail_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; waits for pready with a bound
  task automatic xfer(input logic w, input logic [GPB_AW-1:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next call never re-raises psel in this time step
    @(posedge mclk);
    if (n >= 50) begin
      fail_count++;
      test_done();
    end
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] t;
    logic e;
    xfer(1'b1, {2'b00, idx, 2'b00}, {24'h0, v}, t, e);
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [31:0] v);
    logic e;
    xfer(1'b0, {2'b00, idx, 2'b00}, 32'h0, v, e);
  endtask : rd

  task automatic settle;
    repeat (6) @(posedge mclk);
  endtask : settle

  initial begin
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b0, {2'b00, rst_idx[i], 2'b00}, 32'h0, d, err);
      check({d[31:1], err}, {24'h0, rst_val[i][7:1], 1'b0});
      check(d[0], rst_val[i][0]);
    end
    check({pb_pullup, pb_oe}, 16'h0000);
    xfer(1'b0, 12'h100, 32'h0, d, err);
    check(d, 32'h0);
    check(err, 1'b1);
    xfer(1'b1, 12'h019, 32'hFF, d, err);
    check(err, 1'b1);
    wr(GPB_IDX_LVP, 8'h00);
    wr(GPB_IDX_PB_DATA, 8'hA5);
    wr(GPB_IDX_PB_DIR, 8'h0F);
    settle();
    check({pb_oe, pb_out & pb_oe}, 16'hF0A0);
    rd(GPB_IDX_PB_DATA, d);
    check(d, 32'hAC);
    check(pb_pullup, 8'h00);
    wr(GPB_IDX_OPTION, 8'h7F);
    settle();
    check(pb_pullup, 8'h0F);
    ext_en <= 8'hFB;
    ext_b <= 8'h38;
    settle();
    rd(GPB_IDX_PB_DATA, d);
    check(d[2], 1'b1);
    ext_en <= 8'hFF;
    wr(GPB_IDX_PB_DIR, 8'h07);
    wr(GPB_IDX_LVP, 8'h01);
    settle();
    check(pb_oe[3], 1'b0);
    rd(GPB_IDX_PB_DATA, d);
    check(d[3], 1'b0);
    wr(GPB_IDX_LVP, 8'h00);
    settle();
    check(pb_oe[3], 1'b1);
    // bit 4 driven low as output while the keypad side holds it high
    wr(GPB_IDX_PB_DIR, 8'hEF);
    wr(GPB_IDX_IRQ_EN, 8'h03);
    settle();
    rd(GPB_IDX_PB_DATA, d);
    wr(GPB_IDX_IRQ_CLR, 8'h03);
    ext_b <= 8'h3E;
    settle();
    rd(GPB_IDX_IRQ_STAT, d);
    check(d, 32'h0);
    check(irq, 1'b0);
    ext_b <= 8'h1E;
    settle();
    rd(GPB_IDX_IRQ_STAT, d);
    check(d, 32'h1);
    check(irq, 1'b1);
    wr(GPB_IDX_IRQ_CLR, 8'h01);
    rd(GPB_IDX_IRQ_STAT, d);
    check(d, 32'h1);
    rd(GPB_IDX_PB_DATA, d);
    wr(GPB_IDX_IRQ_CLR, 8'h01);
    settle();
    rd(GPB_IDX_IRQ_STAT, d);
    check(d, 32'h0);
    check(irq, 1'b0);
    sleep <= 1'b1;
    ext_b <= 8'h5E;
    settle();
    check(wake, 1'b1);
    sleep <= 1'b0;
    rd(GPB_IDX_PB_DATA, d);
    wr(GPB_IDX_IRQ_CLR, 8'h01);
    check(wake, 1'b0);
    for (int e = 0; e < 2; e++) begin
      wr(GPB_IDX_OPTION, {1'b0, e[0], 6'h3F});
      ext_b[0] <= ~e[0];
      settle();
      wr(GPB_IDX_IRQ_CLR, 8'h02);
      rd(GPB_IDX_IRQ_STAT, d);
      check(d[1], 1'b0);
      ext_b[0] <= e[0];
      settle();
      rd(GPB_IDX_IRQ_STAT, d);
      check({d[1], irq}, 2'b11);
    end
    wr(GPB_IDX_IRQ_EN, 8'h00);
    settle();
    check(irq, 1'b0);
    rd(GPB_IDX_PA_DATA, d);
    check(d, 32'h10);
    wr(GPB_IDX_ANA, 8'h06);
    rd(GPB_IDX_PA_DATA, d);
    check(d, 32'h3F);
    wr(GPB_IDX_PA_DATA, 8'h00);
    wr(GPB_IDX_PA_DIR, 8'h00);
    settle();
    check({pa_oe[4], pa_out[4], timer_clk}, 3'b100);
    wr(GPB_IDX_PA_DATA, 8'h10);
    settle();
    check({pa_oe[4], pa_out[4], timer_clk}, 3'b001);
    // clock enable low holds the synchroniser, so the pin change waits
    ce <= 1'b0;
    ext_a <= 6'h2F;
    settle();
    check(timer_clk, 1'b1);
    ce <= 1'b1;
    settle();
    check(timer_clk, 1'b0);
    test_done();
  end
endmodule : gpio_ports_a_b_change_irq_test
`default_nettype wire
